// ==== rtl/status_pins_defs.vh ====
// offsets, fields, reset values and timing for the status pin block
`ifndef STATUS_PINS_DEFS_VH
`define STATUS_PINS_DEFS_VH

// register byte offsets
`define OFS_PIN_MODE 8'h00
`define OFS_STAT1_CFG 8'h04
`define OFS_STAT2_CFG 8'h08
`define OFS_MAX_POWER 8'h0C
`define OFS_GPIO_CTRL 8'h10
`define OFS_STATUS 8'h14
`define OFS_RESET_CMD 8'h18

// pin mode fields
`define MODE_TX_IND_BIT 0
`define MODE_RX_IND_BIT 1
`define PIN_MODE_RESET 2'h0

// status output config fields
`define CFG_POL_BIT 0
`define CFG_BUSRST_BIT 1
`define CFG_SUSP_BIT 2
`define CFG_UNSAFE_BIT 3
`define CFG_OD_BIT 4
`define STAT1_CFG_RESET 5'h05
`define STAT2_CFG_RESET 5'h04

// current threshold of one unit load
`define MAX_POWER_LOW_LIMIT 8'h32
`define MAX_POWER_RESET 8'h32

// gpio control fields
`define GPIO_DIR8_BIT 0
`define GPIO_DIR9_BIT 1
`define GPIO_OUT8_BIT 2
`define GPIO_OUT9_BIT 3
`define GPIO_PU8_BIT 4
`define GPIO_PU9_BIT 5
`define GPIO_CTRL_RESET 6'h30

// reset command field
`define RESET_CMD_BIT 0

// timing
`define CLK_HZ 40000000
`define TOGGLE_MS 100
`define RESET_IN_MIN_US 15
`define RESET_DRIVE_CYCLES 16

// axi responses
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// ==== rtl/activity_blinker.v ====
// toggles an indicator at a fixed interval while activity is present

module activity_blinker #(
  parameter HALF_CYCLES = 4000000
) (
  input wire aclk,
  input wire aresetn,
  input wire active,
  output reg blink
);

  reg [31:0] count;

  // count core clocks while busy, flip at each interval, rest high
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      count <= 32'h0000_0000;
      blink <= 1'b1;
    end
    else if (!active)
    begin
      count <= 32'h0000_0000;
      blink <= 1'b1;
    end
    else if (count >= HALF_CYCLES - 1)
    begin
      count <= 32'h0000_0000;
      blink <= ~blink;
    end
    else
    begin
      count <= count + 32'h0000_0001;
    end
  end

endmodule // activity_blinker

// ==== rtl/status_indicator_pins.v ====
// status pins: activity indicators, bus status outputs, reset pin
// Behaviour
// - tx indicator toggles at interval while transmitting
// - rx indicator toggles at interval while receiving
// - indicator pins reset to inputs with pull-up
// - data-line pull-up off without bus power
// - reset pin driven low on any reset
// - second status output, default active-low suspend
// - conditions: bus reset, suspend, unsafe current
// - unsafe current adds unconfigured when power high
// - status deasserts when no condition; first high
`include "status_pins_defs.vh"

module status_indicator_pins #(
  parameter TOGGLE_CYCLES = `CLK_HZ / 1000 * `TOGGLE_MS,
  parameter RESET_IN_CYCLES =
    (`RESET_IN_MIN_US * (`CLK_HZ / 1000000)),
  parameter DRIVE_CYCLES = `RESET_DRIVE_CYCLES
) (
  input wire aclk,
  input wire aresetn,
  input wire [7:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [7:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  input wire uart_tx_busy,
  input wire uart_rx_busy,
  input wire bus_suspended,
  input wire bus_reset_active,
  input wire bus_configured,
  input wire bus_power_sense,
  output reg usb_data_pos_pullup_en,
  input wire chan_a_general_io_8_in,
  output reg chan_a_general_io_8_out,
  output reg chan_a_general_io_8_oe,
  output reg chan_a_general_io_8_pullup,
  input wire chan_a_general_io_9_in,
  output reg chan_a_general_io_9_out,
  output reg chan_a_general_io_9_oe,
  output reg chan_a_general_io_9_pullup,
  output reg bus_status_out_first,
  output reg bus_status_out_second,
  output reg bus_status_out_second_oe,
  input wire reset_pin_n_in,
  output wire reset_pin_n_out,
  output wire reset_pin_n_oe,
  output reg device_reset
);

  // status condition decode shared by both outputs
  function status_level;
    input [4:0] cfg;
    input rst_c;
    input susp_c;
    input unsafe_c;
    reg hit;
    begin
      hit = (cfg[`CFG_BUSRST_BIT] & rst_c) | (cfg[`CFG_SUSP_BIT] & susp_c)
        | (cfg[`CFG_UNSAFE_BIT] & unsafe_c);
      status_level = cfg[`CFG_POL_BIT] ? hit : ~hit;
    end
  endfunction

  reg [1:0] pin_mode;
  reg [4:0] stat1_cfg;
  reg [4:0] stat2_cfg;
  reg [7:0] max_power;
  reg [5:0] gpio_ctrl;
  reg soft_reset;
  reg [7:0] drive_cnt;
  reg [31:0] low_cnt;
  reg ext_reset;
  reg bus_reset_seen;
  wire tx_blink;
  wire rx_blink;
  wire wr_fire;
  wire cfg_reload;
  wire unsafe_now;
  wire stat2_level;
  wire [31:0] status_word;

  assign wr_fire = s_axi_awvalid & s_axi_wvalid & ~s_axi_bvalid;
  assign s_axi_awready = wr_fire;
  assign s_axi_wready = wr_fire;
  assign s_axi_arready = ~s_axi_rvalid;

  // any device reset reloads configuration to its defaults
  assign cfg_reload = !aresetn | device_reset;

  // bus write channel and writable registers
  always @(posedge aclk)
  begin
    if (cfg_reload)
    begin
      pin_mode <= `PIN_MODE_RESET;
      stat1_cfg <= `STAT1_CFG_RESET;
      stat2_cfg <= `STAT2_CFG_RESET;
      max_power <= `MAX_POWER_RESET;
      gpio_ctrl <= `GPIO_CTRL_RESET;
      soft_reset <= 1'b0;
    end
    else
    begin
      soft_reset <= 1'b0;
      if (wr_fire && s_axi_wstrb[0])
      begin
        case (s_axi_awaddr)
          `OFS_PIN_MODE: pin_mode <= s_axi_wdata[1:0];
          `OFS_STAT1_CFG: stat1_cfg <= s_axi_wdata[4:0];
          `OFS_STAT2_CFG: stat2_cfg <= s_axi_wdata[4:0];
          `OFS_MAX_POWER: max_power <= s_axi_wdata[7:0];
          `OFS_GPIO_CTRL: gpio_ctrl <= s_axi_wdata[5:0];
          `OFS_RESET_CMD: soft_reset <= s_axi_wdata[`RESET_CMD_BIT];
          default: soft_reset <= 1'b0;
        endcase
      end
    end
  end

  // write response, one cycle after both channels are taken
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `RESP_OKAY;
    end
    else if (wr_fire)
    begin
      s_axi_bvalid <= 1'b1;
      case (s_axi_awaddr)
        `OFS_PIN_MODE, `OFS_STAT1_CFG, `OFS_STAT2_CFG, `OFS_MAX_POWER,
        `OFS_GPIO_CTRL, `OFS_RESET_CMD, `OFS_STATUS:
          s_axi_bresp <= `RESP_OKAY;
        default: s_axi_bresp <= `RESP_SLVERR;
      endcase
    end
    else if (s_axi_bready)
    begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // live state seen by software
  assign status_word = {22'h00_0000, reset_pin_n_in, chan_a_general_io_9_in,
    chan_a_general_io_8_in, uart_rx_busy, uart_tx_busy, bus_configured,
    bus_reset_active, bus_suspended, bus_power_sense, unsafe_now};

  // read channel, data registered one cycle after address
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `RESP_OKAY;
    end
    else if (s_axi_arvalid && !s_axi_rvalid)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= `RESP_OKAY;
      case (s_axi_araddr)
        `OFS_PIN_MODE: s_axi_rdata <= {30'h0000_0000, pin_mode};
        `OFS_STAT1_CFG: s_axi_rdata <= {27'h000_0000, stat1_cfg};
        `OFS_STAT2_CFG: s_axi_rdata <= {27'h000_0000, stat2_cfg};
        `OFS_MAX_POWER: s_axi_rdata <= {24'h00_0000, max_power};
        `OFS_GPIO_CTRL: s_axi_rdata <= {26'h000_0000, gpio_ctrl};
        `OFS_STATUS: s_axi_rdata <= status_word;
        `OFS_RESET_CMD: s_axi_rdata <= 32'h0000_0000;
        default:
        begin
          s_axi_rdata <= 32'h0000_0000;
          s_axi_rresp <= `RESP_SLVERR;
        end
      endcase
    end
    else if (s_axi_rready)
    begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // activity blinkers for transmit and receive
  activity_blinker #(
    .HALF_CYCLES(TOGGLE_CYCLES)
  ) u_tx_blink (
    .aclk(aclk),
    .aresetn(aresetn),
    .active(uart_tx_busy),
    .blink(tx_blink)
  );

  activity_blinker #(
    .HALF_CYCLES(TOGGLE_CYCLES)
  ) u_rx_blink (
    .aclk(aclk),
    .aresetn(aresetn),
    .active(uart_rx_busy),
    .blink(rx_blink)
  );

  // shared pins: indicator when selected, else plain gpio
  always @(posedge aclk)
  begin
    if (cfg_reload)
    begin
      chan_a_general_io_8_out <= 1'b1;
      chan_a_general_io_8_oe <= 1'b0;
      chan_a_general_io_8_pullup <= 1'b1;
      chan_a_general_io_9_out <= 1'b1;
      chan_a_general_io_9_oe <= 1'b0;
      chan_a_general_io_9_pullup <= 1'b1;
    end
    else
    begin
      if (pin_mode[`MODE_TX_IND_BIT])
      begin
        chan_a_general_io_8_out <= tx_blink;
        chan_a_general_io_8_oe <= 1'b1;
        chan_a_general_io_8_pullup <= 1'b0;
      end
      else
      begin
        chan_a_general_io_8_out <= gpio_ctrl[`GPIO_OUT8_BIT];
        chan_a_general_io_8_oe <= gpio_ctrl[`GPIO_DIR8_BIT];
        chan_a_general_io_8_pullup <= gpio_ctrl[`GPIO_PU8_BIT];
      end
      if (pin_mode[`MODE_RX_IND_BIT])
      begin
        chan_a_general_io_9_out <= rx_blink;
        chan_a_general_io_9_oe <= 1'b1;
        chan_a_general_io_9_pullup <= 1'b0;
      end
      else
      begin
        chan_a_general_io_9_out <= gpio_ctrl[`GPIO_OUT9_BIT];
        chan_a_general_io_9_oe <= gpio_ctrl[`GPIO_DIR9_BIT];
        chan_a_general_io_9_pullup <= gpio_ctrl[`GPIO_PU9_BIT];
      end
    end
  end

  // unsafe current: suspended, or unconfigured on a high power setting
  assign unsafe_now = bus_suspended |
    ((max_power > `MAX_POWER_LOW_LIMIT) & ~bus_configured);
  assign stat2_level = status_level(stat2_cfg, bus_reset_active,
    bus_suspended, unsafe_now);

  // status outputs and data-line pull-up
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      bus_status_out_first <= 1'b0;
      bus_status_out_second <= 1'b1;
      bus_status_out_second_oe <= 1'b1;
      usb_data_pos_pullup_en <= 1'b0;
    end
    else
    begin
      bus_status_out_first <= status_level(stat1_cfg, bus_reset_active,
        bus_suspended, unsafe_now);
      bus_status_out_second <= stat2_level;
      bus_status_out_second_oe <= ~stat2_cfg[`CFG_OD_BIT] | ~stat2_level;
      usb_data_pos_pullup_en <= bus_power_sense & ~device_reset;
    end
  end

  // external reset detect and reset pin drive stretch
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      drive_cnt <= DRIVE_CYCLES[7:0];
      low_cnt <= 32'h0000_0000;
      ext_reset <= 1'b0;
      bus_reset_seen <= 1'b0;
      device_reset <= 1'b1;
    end
    else
    begin
      bus_reset_seen <= bus_reset_active;
      ext_reset <= 1'b0;
      if (drive_cnt != 8'h00 || reset_pin_n_in)
      begin
        low_cnt <= 32'h0000_0000;
      end
      else if (low_cnt == RESET_IN_CYCLES - 1)
      begin
        low_cnt <= low_cnt + 32'h0000_0001;
        ext_reset <= 1'b1;
      end
      else if (low_cnt < RESET_IN_CYCLES)
      begin
        low_cnt <= low_cnt + 32'h0000_0001;
      end
      if (soft_reset || ext_reset || (bus_reset_active && !bus_reset_seen))
      begin
        drive_cnt <= DRIVE_CYCLES[7:0];
      end
      else if (drive_cnt != 8'h00)
      begin
        drive_cnt <= drive_cnt - 8'h01;
      end
      device_reset <= (drive_cnt > 8'h01) | soft_reset | ext_reset;
    end
  end

  // open-drain reset pin: only ever pulls low
  assign reset_pin_n_out = 1'b0;
  assign reset_pin_n_oe = !aresetn | (drive_cnt != 8'h00);

endmodule // status_indicator_pins

// ==== tb/status_pins_checker.sv ====
// assertions on the status pin block ports
module status_pins_checker (
  input wire aclk,
  input wire aresetn,
  input wire s_axi_awvalid,
  input wire s_axi_awready,
  input wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire bus_power_sense,
  input wire usb_data_pos_pullup_en,
  input wire reset_pin_n_in,
  input wire reset_pin_n_oe,
  input wire device_reset,
  input wire chan_a_general_io_8_oe,
  input wire chan_a_general_io_8_pullup,
  input wire bus_status_out_first,
  input wire bus_status_out_second
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // write answer and refusal
  property p_aw; s_axi_awvalid && s_axi_awready |=> s_axi_bvalid; endproperty
  a_aw: assert property (p_aw) else $error("write not answered");
  property p_b; s_axi_bvalid |-> !s_axi_awready; endproperty
  a_b: assert property (p_b) else $error("write taken while busy");
  property p_bd; s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid; endproperty
  a_bd: assert property (p_bd) else $error("write answer held");
  // pins
  property p_pu; !bus_power_sense |=> !usb_data_pos_pullup_en; endproperty
  a_pu: assert property (p_pu) else $error("pull-up on");
  property p_pe; $rose(aresetn) |-> reset_pin_n_oe [*8]; endproperty
  a_pe: assert property (p_pe) else $error("reset pin short");
  property p_dr; device_reset |-> ##[0:1] reset_pin_n_oe; endproperty
  a_dr: assert property (p_dr) else $error("reset not shown");
  property p_df;
    $rose(aresetn) |-> chan_a_general_io_8_pullup && !chan_a_general_io_8_oe;
  endproperty
  a_df: assert property (p_df) else $error("pin not input");
  property p_st;
    $rose(aresetn) |-> !bus_status_out_first && bus_status_out_second;
  endproperty
  a_st: assert property (p_st) else $error("status default");
  property p_ex; (!reset_pin_n_in) [*8] |-> ##[0:8] reset_pin_n_oe; endproperty
  a_ex: assert property (p_ex) else $error("pin reset lost");
endmodule // status_pins_checker

bind status_indicator_pins status_pins_checker i_status_pins_checker (.*);

// ==== tb/board_model.sv ====
// board side of the reset line: pull-up and push button
module board_model (
  input wire hold_low,
  input wire reset_pin_n_out,
  input wire reset_pin_n_oe,
  output wire reset_pin_n_in
);
  timeunit 1ns;
  timeprecision 1ps;
  // weak pull-up; button held as long as the bench asks
  assign reset_pin_n_in = ~(reset_pin_n_oe & ~reset_pin_n_out) & ~hold_low;
endmodule // board_model

// ==== tb/status_indicator_pins_tb.sv ====
// bench for the status pin block
module status_indicator_pins_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0000_0000, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, hold_low = 1'b0;
  logic uart_tx_busy = 1'b0, uart_rx_busy = 1'b0, bus_suspended = 1'b0;
  logic bus_reset_active = 1'b0, bus_configured = 1'b0;
  logic bus_power_sense = 1'b1;
  logic chan_a_general_io_8_in = 1'b1, chan_a_general_io_9_in = 1'b1;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, usb_data_pos_pullup_en, bus_status_out_first;
  logic chan_a_general_io_8_out, chan_a_general_io_8_oe;
  logic chan_a_general_io_8_pullup, chan_a_general_io_9_out;
  logic chan_a_general_io_9_oe, chan_a_general_io_9_pullup;
  logic bus_status_out_second, bus_status_out_second_oe;
  logic reset_pin_n_in, reset_pin_n_out, reset_pin_n_oe, device_reset;
  int fail_count = 0;
  int check_count = 0;
  int n [2];
  logic [1:0] cur, prv;
  logic [7:0] ofs [7] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h18, 8'h1C};
  logic [7:0] rv [7] = '{8'h00, 8'h05, 8'h04, 8'h32, 8'h30, 8'h00, 8'h00};

  status_indicator_pins #(.TOGGLE_CYCLES(8), .RESET_IN_CYCLES(6))
    i_status_indicator_pins (.*);
  board_model i_board_model (.*);

  // clock
  initial
  begin
    forever #12.5 aclk = ~aclk;
  end

  task chk(input logic [31:0] g, input logic [31:0] e);
    check_count++;
    if (g !== e)
    begin
      fail_count++;
      $display("ERROR %0t got %h expected %h", $time, g, e);
    end
  endtask

  task w(input int c);
    repeat (c) @(posedge aclk);
    @(negedge aclk);
  endtask

  task wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] r);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h00_0000, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do @(negedge aclk); while (s_axi_awready !== 1'b1);
    @(posedge aclk);
    s_axi_awvalid <= 1'b0;
    s_axi_wvalid <= 1'b0;
    do @(negedge aclk); while (s_axi_bvalid !== 1'b1);
    chk(s_axi_bresp, r);
    @(posedge aclk);
    s_axi_bready <= 1'b0;
  endtask

  task rd(input logic [7:0] a, input logic [7:0] d, input logic [1:0] r);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(negedge aclk); while (s_axi_arready !== 1'b1);
    @(posedge aclk);
    s_axi_arvalid <= 1'b0;
    do @(negedge aclk); while (s_axi_rvalid !== 1'b1);
    chk(s_axi_rdata, {24'h00_0000, d});
    chk(s_axi_rresp, r);
    @(posedge aclk);
    s_axi_rready <= 1'b0;
  endtask

  // button press of c cycles, then look for the reset drive
  task press(input int c, input logic e);
    logic s;
    s = 1'b0;
    @(posedge aclk);
    hold_low <= 1'b1;
    repeat (c) @(posedge aclk);
    hold_low <= 1'b0;
    repeat (24)
    begin
      @(negedge aclk);
      s = s | reset_pin_n_oe;
    end
    chk(s, e);
    w(10);
  endtask

  task print_verdict;
    $display("checks %0d errors %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // watchdog
  initial
  begin
    repeat (20000) @(posedge aclk);
    fail_count++;
    print_verdict;
  end

  // main sequence
  initial
  begin
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    w(20);
    for (int i = 0; i < 7; i++) rd(ofs[i], rv[i], i == 6 ? 2'h2 : 2'h0);
    @(negedge aclk);
    chk({chan_a_general_io_8_oe, chan_a_general_io_9_oe}, 0);
    chk({chan_a_general_io_8_pullup, chan_a_general_io_9_pullup}, 3);
    chk({bus_status_out_first, bus_status_out_second}, 1);
    chk(bus_status_out_second_oe, 1);
    @(posedge aclk);
    bus_suspended <= 1'b1;
    w(2);
    chk({bus_status_out_first, bus_status_out_second}, 2);
    @(posedge aclk);
    bus_suspended <= 1'b0;
    wr(8'h04, 8'h0B, 2'h0);
    w(2);
    chk(bus_status_out_first, 0);
    wr(8'h0C, 8'h33, 2'h0);
    w(2);
    chk(bus_status_out_first, 1);
    @(posedge aclk);
    bus_configured <= 1'b1;
    w(2);
    chk(bus_status_out_first, 0);
    @(posedge aclk);
    bus_reset_active <= 1'b1;
    w(2);
    chk(reset_pin_n_in, 0);
    chk(bus_status_out_first, 1);
    @(posedge aclk);
    bus_reset_active <= 1'b0;
    w(30);
    rd(8'h04, 8'h05, 2'h0);
    wr(8'h08, 8'h14, 2'h0);
    w(2);
    chk({bus_status_out_second, bus_status_out_second_oe}, 2);
    wr(8'h08, 8'h05, 2'h0);
    wr(8'h18, 8'h01, 2'h0);
    @(negedge aclk);
    chk(reset_pin_n_in, 0);
    w(30);
    rd(8'h08, 8'h04, 2'h0);
    @(posedge aclk);
    bus_power_sense <= 1'b0;
    w(2);
    chk(usb_data_pos_pullup_en, 0);
    @(posedge aclk);
    bus_power_sense <= 1'b1;
    w(2);
    chk(usb_data_pos_pullup_en, 1);
    wr(8'h00, 8'h03, 2'h0);
    for (int k = 0; k < 2; k++)
    begin
      @(posedge aclk);
      uart_tx_busy <= 1'b0;
      uart_rx_busy <= 1'b0;
      w(3);
      chk({chan_a_general_io_9_out, chan_a_general_io_8_out}, 3);
      chk({chan_a_general_io_9_oe, chan_a_general_io_8_oe}, 3);
      @(posedge aclk);
      uart_tx_busy <= k == 0;
      uart_rx_busy <= k == 1;
      n = '{0, 0};
      prv = 2'h3;
      repeat (40)
      begin
        @(negedge aclk);
        cur = {chan_a_general_io_9_out, chan_a_general_io_8_out};
        for (int j = 0; j < 2; j++) n[j] += cur[j] != prv[j];
        prv = cur;
      end
      chk(n[k] == 4 || n[k] == 5, 1);
      chk(n[1 - k], 0);
    end
    press(6, 1'b1);
    press(10, 1'b1);
    print_verdict;
  end
endmodule // status_indicator_pins_tb
